// ---- sds_sample_control.sv ----
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sds_sample_control (
   input  wire logic                        sys_clk,
   input  wire logic                        arst_n,
   input  wire logic [sds_pkg::ADDR_W-1:0]  regAddr,
   input  wire logic [sds_pkg::DATA_W-1:0]  regWdata,
   input  wire logic                        regWr,
   input  wire logic                        regRd,
   output logic      [sds_pkg::DATA_W-1:0]  regRdata,
   input  wire logic                        modBitPin,
   output logic                             integratorRun,
   output logic                             pwmOut,
   output logic                             irq
);
   import sds_pkg::*;

   typedef struct packed {
      sds_run_type       run;
      logic              signedFmt;
      logic [1:0]        rateSel;
      logic [DATA_W-1:0] compare;
      logic [DATA_W-1:0] result;
      logic              ready;
      logic [IRQ_W-1:0]  irqStat;
      logic [IRQ_W-1:0]  irqMask;
      logic [DATA_W-1:0] rdata;
      logic              sync1;
      logic              sync2;
   } sds_ctrl_type;

   sds_ctrl_type      st_r;
   sds_ctrl_type      st_nxt;

   logic              timerEn;
   logic [9:0]        period;
   logic [DATA_W-1:0] cmpEff;
   logic              tcPulse;
   logic              bitTick;
   logic              dutyOk;
   logic [DATA_W-1:0] sample;
   logic              sampleValid;
   logic              capture;
   logic              wrCtrl;
   logic              wrStatus;
   logic              wrIrqStat;
   logic              ackRead;
   logic              clrReady;
   logic [IRQ_W-1:0]  irqEvent;

   assign timerEn = (st_r.run == ST_RUNNING);
   assign period  = sds_period(st_r.rateSel);

   // short rates use only the low compare byte
   assign cmpEff = (st_r.rateSel == RATE_32 || st_r.rateSel == RATE_64) ?
                   (st_r.compare & BYTE_MASK) : st_r.compare;

   sds_pulse_timer u_timer (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .enable  (timerEn),
      .period  (period),
      .compare (cmpEff),
      .tcPulse (tcPulse),
      .bitTick (bitTick),
      .pwmOut  (pwmOut),
      .dutyOk  (dutyOk)
   );

   sds_sinc2_decim u_decim (
      .sys_clk     (sys_clk),
      .arst_n      (arst_n),
      .clearInt    (!timerEn),
      .bitTick     (bitTick),
      .modBit      (st_r.sync2),
      .dump        (tcPulse),
      .deliver     (dutyOk),
      .signedFmt   (st_r.signedFmt),
      .rateSel     (st_r.rateSel),
      .sample      (sample),
      .sampleValid (sampleValid)
   );

   // the filter needs two dumps after a start before its output settles
   assign capture   = sampleValid && timerEn;
   assign wrCtrl    = regWr && (regAddr == OFF_CTRL);
   assign wrStatus  = regWr && (regAddr == OFF_STATUS);
   assign wrIrqStat = regWr && (regAddr == OFF_IRQ_STAT);
   assign ackRead   = regRd && (regAddr == OFF_ACK);
   assign clrReady  = (wrStatus && regWdata[STAT_READY]) || ackRead;

   always_comb begin
      irqEvent              = '0;
      irqEvent[IRQ_SAMPLE]  = capture;
      irqEvent[IRQ_OVERRUN] = capture && st_r.ready && !clrReady;
      irqEvent[IRQ_STALL]   = tcPulse && !dutyOk;
   end

   always_comb begin
      st_nxt       = st_r;
      st_nxt.sync1 = modBitPin;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.rdata = '0;

      if (wrCtrl) begin
         st_nxt.signedFmt = regWdata[CTRL_SIGNED];
         st_nxt.rateSel   = regWdata[CTRL_RATE_LO +: 2];
         // halt wins when both command bits are written together
         if (regWdata[CTRL_HALT]) begin
            st_nxt.run = ST_HALTED;
         end else if (regWdata[CTRL_BEGIN]) begin
            st_nxt.run = ST_RUNNING;
         end
      end

      if (regWr && regAddr == OFF_PW_LO) begin
         st_nxt.compare[7:0] = regWdata[7:0];
      end
      if (regWr && regAddr == OFF_PW_HI) begin
         st_nxt.compare[15:8] = regWdata[7:0];
      end

      // a capture in the clearing cycle must not be lost
      if (clrReady) begin
         st_nxt.ready = 1'b0;
      end
      if (capture) begin
         st_nxt.result = sample;
         st_nxt.ready  = 1'b1;
      end

      if (regWr && regAddr == OFF_IRQ_MASK) begin
         st_nxt.irqMask = regWdata[IRQ_W-1:0];
      end
      if (wrIrqStat) begin
         st_nxt.irqStat = st_r.irqStat & ~regWdata[IRQ_W-1:0];
      end
      st_nxt.irqStat = st_nxt.irqStat | irqEvent;

      if (regRd) begin
         case (regAddr)
            OFF_CTRL: begin
               st_nxt.rdata[CTRL_BEGIN]        = timerEn;
               st_nxt.rdata[CTRL_SIGNED]       = st_r.signedFmt;
               st_nxt.rdata[CTRL_RATE_LO +: 2] = st_r.rateSel;
            end
            OFF_STATUS: begin
               st_nxt.rdata[STAT_READY] = st_r.ready;
            end
            OFF_RESULT, OFF_ACK: begin
               st_nxt.rdata = st_r.result;
            end
            OFF_PW_LO: begin
               st_nxt.rdata[7:0] = st_r.compare[7:0];
            end
            OFF_PW_HI: begin
               st_nxt.rdata[7:0] = st_r.compare[15:8];
            end
            OFF_IRQ_STAT: begin
               st_nxt.rdata[IRQ_W-1:0] = st_r.irqStat;
            end
            OFF_IRQ_MASK: begin
               st_nxt.rdata[IRQ_W-1:0] = st_r.irqMask;
            end
            default: begin
               st_nxt.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r           <= '0;
         st_r.run       <= ST_HALTED;
         st_r.rateSel   <= RATE_RESET;
         st_r.compare   <= PW_RESET;
         st_r.result    <= RESULT_RESET;
         st_r.irqMask   <= MASK_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign regRdata      = st_r.rdata;
   assign integratorRun = timerEn;
   assign irq           = |(st_r.irqStat & st_r.irqMask);

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   a_begin_runs: assert property (
      wrCtrl && regWdata[CTRL_BEGIN] && !regWdata[CTRL_HALT] |=> integratorRun ##1 (integratorRun || $past(wrCtrl)))
      else $error("begin command did not start conversion");

   a_halt_stops: assert property (
      wrCtrl && regWdata[CTRL_HALT] |=> !integratorRun ##1 !pwmOut)
      else $error("halt command did not stop timer and integrator");

   a_ready_view: assert property (
      regRd && regAddr == OFF_STATUS |=> (regRdata != 16'h0000) == $past(st_r.ready))
      else $error("ready read does not match flag");

   a_clear_keeps: assert property (
      wrStatus && regWdata[STAT_READY] && !capture |=> !st_r.ready && $stable(st_r.result))
      else $error("flag clear failed or altered result");

   a_ack_read: assert property (
      ackRead && !capture |=> !st_r.ready && regRdata == $past(st_r.result))
      else $error("acknowledge read wrong data or flag");

   a_raw_view: assert property (
      regRd && regAddr == OFF_RESULT && !capture |=> regRdata == st_r.result && $stable(st_r.ready))
      else $error("result view altered data or flag");

   a_pw_load: assert property (
      regWr && regAddr == OFF_PW_LO |=> st_r.compare[7:0] == $past(regWdata[7:0]))
      else $error("pulse width low byte not loaded");

   a_stall_gate: assert property (
      tcPulse && !dutyOk |=> !sampleValid)
      else $error("sample delivered at zero or full duty");

   a_capture_set: assert property (
      capture |=> st_r.ready && st_r.result == $past(sample))
      else $error("capture did not store sample and set ready");

   a_overrun_keep: assert property (
      capture && st_r.ready && !clrReady |=> st_r.ready && st_r.irqStat[IRQ_OVERRUN])
      else $error("overwrite lost ready or overrun flag");

   a_halted_idle: assert property (
      !integratorRun && !(wrCtrl && regWdata[CTRL_BEGIN]) |=> !integratorRun && !capture)
      else $error("conversion ran without begin command");

   a_ready_hold: assert property (
      st_r.ready && !clrReady |=> st_r.ready)
      else $error("ready dropped without a clear");

   a_ready_source: assert property (
      !st_r.ready && !capture |=> !st_r.ready)
      else $error("ready set without a capture");

   a_result_hold: assert property (
      !capture |=> $stable(st_r.result))
      else $error("result changed without a capture");

   a_status_zero: assert property (
      wrStatus && !regWdata[STAT_READY] && st_r.ready |=> st_r.ready)
      else $error("status write of zero cleared ready");

   a_set_wins: assert property (
      capture && clrReady |=> st_r.ready && st_r.result == $past(sample))
      else $error("clear beat a capture in the same cycle");

   a_pw_high: assert property (
      regWr && regAddr == OFF_PW_HI |=> st_r.compare[15:8] == $past(regWdata[7:0]))
      else $error("pulse width high byte not loaded");

   a_signed_cfg: assert property (
      wrCtrl |=> st_r.signedFmt == $past(regWdata[CTRL_SIGNED]))
      else $error("format select not taken from control write");

   a_duty_deliver: assert property (
      tcPulse && dutyOk && integratorRun |=> sampleValid)
      else $error("sample withheld at a legal duty cycle");

   a_stall_flag: assert property (
      tcPulse && !dutyOk |=> st_r.irqStat[IRQ_STALL])
      else $error("stall not flagged at zero or full duty");

   a_capture_irq: assert property (
      capture |=> st_r.irqStat[IRQ_SAMPLE])
      else $error("capture did not flag sample event");

   a_capture_tc: assert property (
      capture |-> $past(tcPulse))
      else $error("capture without a terminal count");

   a_run_source: assert property (
      $changed(st_r.run) |-> $past(wrCtrl))
      else $error("run state changed without control write");

   a_run_holds: assert property (
      integratorRun && !wrCtrl |=> integratorRun)
      else $error("conversion stopped without halt command");

   a_halt_no_tc: assert property (
      !integratorRun |=> !tcPulse)
      else $error("terminal count while halted");
endmodule
`default_nettype wire

// ---- sds_pkg.sv ----
`default_nettype none
package sds_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;

   // register offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL     = 3'h0;
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 3'h1;
   localparam logic [ADDR_W-1:0] OFF_RESULT   = 3'h2;
   localparam logic [ADDR_W-1:0] OFF_ACK      = 3'h3;
   localparam logic [ADDR_W-1:0] OFF_PW_LO    = 3'h4;
   localparam logic [ADDR_W-1:0] OFF_PW_HI    = 3'h5;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 3'h6;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 3'h7;

   // field positions
   localparam int CTRL_BEGIN   = 0;
   localparam int CTRL_HALT    = 1;
   localparam int CTRL_SIGNED  = 2;
   localparam int CTRL_RATE_LO = 4;
   localparam int STAT_READY   = 0;
   localparam int IRQ_SAMPLE   = 0;
   localparam int IRQ_OVERRUN  = 1;
   localparam int IRQ_STALL    = 2;
   localparam int IRQ_W        = 3;

   // decimation rate codes: 32, 64, 128, 256
   localparam logic [1:0] RATE_32  = 2'h0;
   localparam logic [1:0] RATE_64  = 2'h1;
   localparam logic [1:0] RATE_128 = 2'h2;
   localparam logic [1:0] RATE_256 = 2'h3;

   // reset values
   localparam logic [1:0]        RATE_RESET   = RATE_64;
   localparam logic [DATA_W-1:0] PW_RESET     = 16'h0080;
   localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;
   localparam logic [IRQ_W-1:0]  MASK_RESET   = 3'h0;

   // timing and scaling
   localparam logic [10:0] QUAD_BASE  = 11'h080;
   localparam logic [1:0]  TICK_PHASE = 2'h0;
   localparam logic [16:0] HALF_BASE  = 17'h00200;
   localparam logic [15:0] BYTE_MASK  = 16'h00ff;
   localparam logic [15:0] U_SAT      = 16'hffff;
   localparam logic [15:0] S_SAT      = 16'h7fff;

   typedef enum logic [0:0] {
      ST_HALTED  = 1'b0,
      ST_RUNNING = 1'b1
   } sds_run_type;

   // timer period: four times the rate, less one
   function automatic logic [9:0] sds_period(input logic [1:0] rate);
      logic [10:0] quad;
      quad = 11'(QUAD_BASE << rate);
      return 10'(quad - 11'h001);
   endfunction
endpackage
`default_nettype wire

// ---- sds_pulse_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module sds_pulse_timer (
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire logic       enable,
   input  wire logic [9:0] period,
   input  wire logic [15:0] compare,
   output logic            tcPulse,
   output logic            bitTick,
   output logic            pwmOut,
   output logic            dutyOk
);
   import sds_pkg::*;

   typedef struct packed {
      logic [9:0] cnt;
      logic       pwm;
      logic       tc;
      logic       tick;
   } sds_timer_type;

   sds_timer_type st_r;
   sds_timer_type st_nxt;
   logic [9:0]    cntNext;

   // zero or full-period compare means no falling edge, so no samples
   assign dutyOk = (compare != 16'h0000) && (compare <= {6'h00, period});

   always_comb begin
      st_nxt  = st_r;
      cntNext = (st_r.cnt == 10'h000) ? period : 10'(st_r.cnt - 10'h001);
      if (!enable) begin
         st_nxt.cnt  = period;
         st_nxt.pwm  = 1'b0;
         st_nxt.tc   = 1'b0;
         st_nxt.tick = 1'b0;
      end else begin
         st_nxt.cnt  = cntNext;
         st_nxt.tc   = (st_r.cnt == 10'h000);
         st_nxt.tick = (st_r.cnt[1:0] == TICK_PHASE);
         st_nxt.pwm  = ({6'h00, cntNext} < compare);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tcPulse = st_r.tc;
   assign bitTick = st_r.tick;
   assign pwmOut  = st_r.pwm;

   a_period_reload: assert property (@(posedge sys_clk) disable iff (!arst_n)
      enable && st_r.cnt == 10'h000 |=> st_r.cnt == $past(period) && tcPulse)
      else $error("timer did not reload period at terminal count");

   a_disabled_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !enable |=> !tcPulse && !pwmOut && !bitTick)
      else $error("timer active while disabled");
endmodule
`default_nettype wire

// ---- sds_sinc2_decim.sv ----
`timescale 1ns/1ps
`default_nettype none
module sds_sinc2_decim (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        clearInt,
   input  wire logic        bitTick,
   input  wire logic        modBit,
   input  wire logic        dump,
   input  wire logic        deliver,
   input  wire logic        signedFmt,
   input  wire logic [1:0]  rateSel,
   output logic [15:0]      sample,
   output logic             sampleValid
);
   import sds_pkg::*;

   typedef struct packed {
      logic [17:0] i1;
      logic [17:0] i2;
      logic [17:0] z1;
      logic [17:0] z2;
      logic [15:0] sample;
      logic        valid;
   } sds_decim_type;

   sds_decim_type st_r;
   sds_decim_type st_nxt;
   logic [17:0]   d1;
   logic [17:0]   raw;
   logic [17:0]   sgn;
   logic [16:0]   half;

   always_comb begin
      st_nxt       = st_r;
      st_nxt.valid = 1'b0;
      half = 17'(HALF_BASE << {rateSel, 1'b0});
      d1   = 18'(st_r.i2 - st_r.z1);
      raw  = 18'(d1 - st_r.z2);
      sgn  = 18'(raw - {1'b0, half});
      if (clearInt) begin
         st_nxt.i1 = '0;
         st_nxt.i2 = '0;
         st_nxt.z1 = '0;
         st_nxt.z2 = '0;
      end else begin
         if (bitTick) begin
            st_nxt.i1 = 18'(st_r.i1 + {17'h00000, modBit});
            st_nxt.i2 = 18'(st_r.i2 + st_r.i1);
         end
         if (dump) begin
            st_nxt.z1    = st_r.i2;
            st_nxt.z2    = d1;
            st_nxt.valid = deliver;
            // encoding is fixed here; reads never convert it again
            if (signedFmt) begin
               st_nxt.sample = (!sgn[17] && (sgn[16] || sgn[15])) ? S_SAT : sgn[15:0];
            end else begin
               st_nxt.sample = (raw[17:16] != 2'h0) ? U_SAT : raw[15:0];
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sample      = st_r.sample;
   assign sampleValid = st_r.valid;
endmodule
`default_nettype wire

// ---- sds_mod_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// modulator stand-in: all-ones or all-zeros density, registered like a comparator
// a constant stream keeps the sinc2 result exact once the two transient samples pass
module sds_mod_source (
   input  wire logic sys_clk,
   input  wire logic high,
   output logic      modBit
);
   always_ff @(posedge sys_clk) begin
      modBit <= high;
   end
endmodule
`default_nettype wire

// ---- sigma_delta_sample_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sigma_delta_sample_control_tb_top;
   import sds_pkg::*;
   logic              sys_clk  = 1'b0;
   logic              arst_n   = 1'b0;
   logic [ADDR_W-1:0] regAddr  = '0;
   logic [DATA_W-1:0] regWdata = '0;
   logic              regWr    = 1'b0;
   logic              regRd    = 1'b0;
   logic              modHigh  = 1'b0;
   logic [DATA_W-1:0] regRdata;
   logic              modBit;
   logic              integratorRun;
   logic              pwmOut;
   logic              irq;
   logic [DATA_W-1:0] d;
   logic [DATA_W-1:0] r;
   int                mismatches = 0;
   int                compares   = 0;
   int                cyc        = 0;
   int                tRise      = 0;
   int                tGap       = 0;

   always #5 sys_clk = ~sys_clk;

   sds_sample_control i_dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .modBitPin(modBit), .integratorRun(integratorRun),
      .pwmOut(pwmOut), .irq(irq)
   );
   sds_mod_source i_src (.sys_clk(sys_clk), .high(modHigh), .modBit(modBit));

   task automatic results;
      if (mismatches == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // a hang costs far more than the ~10k cycles the scenarios need
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 60000) begin
         mismatches++;
         results;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // a cycle gap after each access keeps one strobe assignment per time step
   task automatic wr(input logic [2:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      regAddr  <= a;
      regWdata <= v;
      regWr    <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      v = regRdata;
   endtask

   task automatic rdChk(input logic [2:0] a, input logic [15:0] exp);
      logic [15:0] v;
      rd(a, v);
      chk(v, exp);
   endtask

   // waits for the sample interrupt n times, clearing it each time; tGap is the last interval
   task automatic waitCap(input int n);
      int k;
      repeat (n) begin
         k = 0;
         do begin
            @(posedge sys_clk);
            #1;
            k++;
         end while (irq !== 1'b1 && k < 2100);
         if (k >= 2100) chk(16'h0bad, 16'h0000);
         tGap  = cyc - tRise;
         tRise = cyc;
         wr(OFF_IRQ_STAT, 16'h0001);
      end
   endtask

   task automatic resetVals;
      rdChk(OFF_CTRL, 16'h0010);
      rdChk(OFF_STATUS, 16'h0000);
      rdChk(OFF_RESULT, 16'h0000);
      rdChk(OFF_PW_LO, 16'h0080);
      rdChk(OFF_PW_HI, 16'h0000);
      rdChk(OFF_IRQ_MASK, 16'h0000);
      chk({15'h0, integratorRun}, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
   endtask

   task automatic startRun;
      wr(OFF_IRQ_MASK, 16'h0001);
      // the reset width is full duty at rate 32, which would stall every sample
      wr(OFF_PW_LO, 16'h0040);
      wr(OFF_CTRL, 16'h0001);
      #1;
      chk({15'h0, integratorRun}, 16'h0001);
      rdChk(OFF_CTRL, 16'h0001);
      modHigh <= 1'b1;
      waitCap(3);
      #1;
      chk({15'h0, irq}, 16'h0000);
      rdChk(OFF_RESULT, 16'h0400);
      chk(16'(tGap), 16'd128);
   endtask

   task automatic readyFlag;
      wr(OFF_STATUS, 16'h0001);
      rdChk(OFF_STATUS, 16'h0000);
      waitCap(1);
      wr(OFF_STATUS, 16'h0000);
      rdChk(OFF_STATUS, 16'h0001);
      rd(OFF_RESULT, r);
      wr(OFF_STATUS, 16'h0001);
      rdChk(OFF_STATUS, 16'h0000);
      rdChk(OFF_RESULT, r);
   endtask

   task automatic signedView;
      wr(OFF_CTRL, 16'h0005);
      waitCap(3);
      rdChk(OFF_RESULT, 16'h0200);
      rdChk(OFF_ACK, 16'h0200);
      rdChk(OFF_STATUS, 16'h0000);
      modHigh <= 1'b0;
      waitCap(3);
      rdChk(OFF_RESULT, 16'hfe00);
      wr(OFF_CTRL, 16'h0001);
   endtask

   task automatic overrun;
      modHigh <= 1'b1;
      wr(OFF_STATUS, 16'h0001);
      wr(OFF_IRQ_STAT, 16'h0007);
      waitCap(3);
      rdChk(OFF_STATUS, 16'h0001);
      rdChk(OFF_RESULT, 16'h0400);
      rd(OFF_IRQ_STAT, d);
      chk(d & 16'h0002, 16'h0002);
   endtask

   // compare 0 and compare above the 127 period of rate 32 both stall
   task automatic stallDuty;
      int hi;
      logic [15:0] pw[2] = '{16'h0000, 16'h0080};
      for (int i = 0; i < 2; i++) begin
         wr(OFF_PW_LO, pw[i]);
         rdChk(OFF_PW_LO, pw[i]);
         wr(OFF_IRQ_MASK, 16'h0004);
         wr(OFF_STATUS, 16'h0001);
         wr(OFF_IRQ_STAT, 16'h0007);
         repeat (300) @(posedge sys_clk);
         rdChk(OFF_STATUS, 16'h0000);
         #1;
         chk({15'h0, irq}, 16'h0001);
         wr(OFF_IRQ_STAT, 16'h0004);
         #1;
         chk({15'h0, irq}, 16'h0000);
      end
      wr(OFF_PW_LO, 16'h0040);
      wr(OFF_IRQ_MASK, 16'h0001);
      hi = 0;
      repeat (256) begin
         @(posedge sys_clk);
         #1;
         hi += int'(pwmOut === 1'b1);
      end
      chk(16'(hi > 0 && hi < 256), 16'h0001);
   endtask

   // at rate 256 the compare 0x0300 has a zero low byte, so only a 16-bit compare keeps sampling
   task automatic rates;
      for (int c = 0; c < 4; c++) begin
         if (c == 3) begin
            wr(OFF_PW_LO, 16'h0000);
            wr(OFF_PW_HI, 16'h0003);
            rdChk(OFF_PW_HI, 16'h0003);
         end
         wr(OFF_CTRL, 16'((c << 4) | 1));
         waitCap(3);
         chk(16'(tGap), 16'(128 << c));
      end
      wr(OFF_PW_HI, 16'h0000);
      wr(OFF_PW_LO, 16'h0040);
   endtask

   task automatic haltConv;
      wr(OFF_CTRL, 16'h0003);
      #1;
      chk({15'h0, integratorRun}, 16'h0000);
      rdChk(OFF_CTRL, 16'h0000);
      wr(OFF_STATUS, 16'h0001);
      repeat (1100) @(posedge sys_clk);
      rdChk(OFF_STATUS, 16'h0000);
   endtask

   initial begin
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      resetVals;
      startRun;
      readyFlag;
      signedView;
      overrun;
      stallDuty;
      rates;
      haltConv;
      results;
   end
endmodule
`default_nettype wire
